// ===== design/srcg_ctrl.v
// Operation
// RULE_01 - bit 7 set holds overclock and both spread engines in reset.
// RULE_02 - bit 6 set holds the tdc pll digital logic in reset.
// RULE_03 - software sets bit 6 while reprogramming tdc pll settings.
// RULE_04 - reset bit n holds clock monitor n in reset; monitor 4 is refin.
// RULE_05 - software holds a monitor reset while reprogramming its settings.
// RULE_06 - gate bit n+1 stops the clock of monitor n.
// RULE_07 - gate bit 0 gates the fuse memory interface clock.
// RULE_08 - software clears gate bit 0 before any fuse memory access.
// RULE_09 - a stored fuse image never sets the fuse interface gate bit.
// RULE_10 - reserved rw bits store only; reserved ro bits read zero.
//
// Local design decisions: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "srcg_defs.vh"

module srcg_ctrl (
    // clock, reset, enable
    input wire ref_clk,
    input wire arst_n,
    input wire clk_en,
    // wishbone classic slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg wb_err_o,
    // sub-block resets, active high
    output reg overclock_spread_engine_reset,
    output reg tdc_pll_logic_reset,
    output wire input0_monitor_reset,
    output wire input1_monitor_reset,
    output wire input2_monitor_reset,
    output wire input3_monitor_reset,
    output wire refin_monitor_reset,
    // clock gate requests, high stops the clock
    output wire input0_monitor_gate,
    output wire input1_monitor_gate,
    output wire input2_monitor_gate,
    output wire input3_monitor_gate,
    output wire refin_monitor_gate,
    output reg fuse_interface_gate
);
    // ==========================================================
    // sizes
    localparam NUM_MON = `SRCG_NUM_MON;

    // ==========================================================
    // bus state
    // one-hot: idle takes a request, answer drives ack or err
    // for exactly one cycle and then returns to idle
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_ANSWER = 2'b10;
    reg [1:0] state_q;
    reg [1:0] state_d;

    // ==========================================================
    // bus decode
    // a request is taken only in idle, so the cycle in which ack
    // stands can never be taken as a second request
    wire req = wb_cyc_i && wb_stb_i && state_q[0];
    wire hit_rst = (wb_adr_i == `SRCG_SWRST_OFS);
    wire hit_cg = (wb_adr_i == `SRCG_CGATE_OFS);
    wire hit = hit_rst || hit_cg;
    // writes need clk_en too; a frozen block must not change state
    wire do_wr = req && wb_we_i && clk_en;
    wire do_rd = req && !wb_we_i;

    always @* begin
        case (state_q)
            ST_IDLE: begin
                if (req) begin
                    state_d = ST_ANSWER;
                end else begin
                    state_d = ST_IDLE;
                end
            end
            ST_ANSWER: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // register storage
    wire [15:0] swrst_val;
    wire [15:0] cgate_val;

    // RULE_10 reserved bit storage
    srcg_cfg_reg #(
        .WMASK(`SRCG_SWRST_WMASK),
        .RST_VAL(`SRCG_SWRST_RST)
    ) u_swrst (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .wr_en(do_wr && hit_rst),
        .byte_en(wb_sel_i[1:0]),
        .wr_data(wb_dat_i[15:0]),
        .value(swrst_val)
    );

    // RULE_10 reserved bit storage, gate word
    srcg_cfg_reg #(
        .WMASK(`SRCG_CGATE_WMASK),
        .RST_VAL(`SRCG_CGATE_RST)
    ) u_cgate (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .wr_en(do_wr && hit_cg),
        .byte_en(wb_sel_i[1:0]),
        .wr_data(wb_dat_i[15:0]),
        .value(cgate_val)
    );

    // ==========================================================
    // read data selection
    // bits 31:16 and the read-only fields come back as zero; an
    // unmapped read also returns zero next to its err strobe
    reg [31:0] rdata_d;
    always @* begin
        rdata_d = 32'h0000_0000;
        if (hit_rst) begin
            rdata_d = {16'h0000, swrst_val};
        end else if (hit_cg) begin
            rdata_d = {16'h0000, cgate_val};
        end
    end

    // ==========================================================
    // bus answer: ack or err one cycle after the request is taken
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (clk_en) begin
            wb_ack_o <= req && hit;
            wb_err_o <= req && !hit;
            // data stands only with the read ack, zero otherwise
            if (do_rd && hit) begin
                wb_dat_o <= rdata_d;
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // ==========================================================
    // field extraction
    // every control bit is pulled out of the stored words here, so
    // the layout lives in one place; reserved bits feed nothing
    wire engine_reset_d;
    wire tdc_reset_d;
    wire fuse_gate_d;
    wire [NUM_MON-1:0] mon_reset_d;
    wire [NUM_MON-1:0] mon_gate_d;
    wire [NUM_MON-1:0] mon_reset_q;
    wire [NUM_MON-1:0] mon_gate_q;

    // RULE_01 engine reset source
    assign engine_reset_d = swrst_val[`SRCG_SWRST_OCSS_BIT];
    // RULE_02 tdc reset source
    assign tdc_reset_d = swrst_val[`SRCG_SWRST_TDC_BIT];
    // RULE_07 fuse gate source
    assign fuse_gate_d = cgate_val[`SRCG_CGATE_FUSE_BIT];
    // RULE_04 monitor reset field
    assign mon_reset_d = swrst_val[`SRCG_SWRST_MON_LSB +: NUM_MON];
    // RULE_06 monitor gate field, one place above its reset bit
    assign mon_gate_d = cgate_val[`SRCG_CGATE_MON_LSB +: NUM_MON];

    // ==========================================================
    // engine, tdc and fuse controls
    // registered so that a bus write can never glitch a reset line
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            overclock_spread_engine_reset <= 1'b0;
            tdc_pll_logic_reset <= 1'b0;
            fuse_interface_gate <= 1'b0;
        end else if (clk_en) begin
            // RULE_01 engine reset hold
            overclock_spread_engine_reset <= engine_reset_d;
            // RULE_02 tdc logic hold
            tdc_pll_logic_reset <= tdc_reset_d;
            // RULE_07 fuse clock gate
            fuse_interface_gate <= fuse_gate_d;
        end
    end

    // ==========================================================
    // per-monitor reset and gate flops
    genvar n;
    generate
        for (n = 0; n < NUM_MON; n = n + 1) begin : g_mon
            reg rst_q;
            reg gate_q;
            // RULE_04 monitor reset hold
            // RULE_06 monitor clock stop
            always @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    rst_q <= 1'b0;
                    gate_q <= 1'b0;
                end else if (clk_en) begin
                    rst_q <= mon_reset_d[n];
                    gate_q <= mon_gate_d[n];
                end
            end
            assign mon_reset_q[n] = rst_q;
            assign mon_gate_q[n] = gate_q;
        end
    endgenerate

    // ==========================================================
    // monitor port map; index 4 serves the reference input
    assign input0_monitor_reset = mon_reset_q[0];
    assign input1_monitor_reset = mon_reset_q[1];
    assign input2_monitor_reset = mon_reset_q[2];
    assign input3_monitor_reset = mon_reset_q[3];
    assign refin_monitor_reset = mon_reset_q[4];
    assign input0_monitor_gate = mon_gate_q[0];
    assign input1_monitor_gate = mon_gate_q[1];
    assign input2_monitor_gate = mon_gate_q[2];
    assign input3_monitor_gate = mon_gate_q[3];
    assign refin_monitor_gate = mon_gate_q[4];
endmodule // srcg_ctrl

`default_nettype wire

// ===== design/srcg_defs.vh
`ifndef SRCG_DEFS_VH
`define SRCG_DEFS_VH

// ==========================================================
// register offsets (byte addresses on the wishbone slave)
`define SRCG_SWRST_OFS 8'h00
`define SRCG_CGATE_OFS 8'h04
`define SRCG_ADDR_W 8

// ==========================================================
// software_reset_control fields
`define SRCG_SWRST_MON_LSB 0
`define SRCG_SWRST_RSVD5_BIT 5
`define SRCG_SWRST_TDC_BIT 6
`define SRCG_SWRST_OCSS_BIT 7
// writable mask: bits 7:0 (upper fields not held by this block)
`define SRCG_SWRST_WMASK 16'h00ff
`define SRCG_SWRST_RST 16'h0000

// ==========================================================
// block_clock_gating fields
`define SRCG_CGATE_FUSE_BIT 0
`define SRCG_CGATE_MON_LSB 1
`define SRCG_CGATE_RSVD6_BIT 6
`define SRCG_CGATE_WMASK 16'h007f
`define SRCG_CGATE_RST 16'h0000

// ==========================================================
// misc
`define SRCG_NUM_MON 5
`define SRCG_ACK_LATENCY 1

`endif

// ===== design/srcg_cfg_reg.v
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// one 16-bit control register with write mask and byte enables
module srcg_cfg_reg #(
    parameter [15:0] WMASK = 16'hffff,
    parameter [15:0] RST_VAL = 16'h0000
) (
    // clock and reset
    input wire ref_clk,
    input wire arst_n,
    input wire clk_en,
    // write port
    input wire wr_en,
    input wire [1:0] byte_en,
    input wire [15:0] wr_data,
    // stored value
    output wire [15:0] value
);
    reg [15:0] reg_q;
    reg [15:0] reg_d;
    integer i;

    always @* begin
        reg_d = reg_q;
        for (i = 0; i < 16; i = i + 1) begin
            if (wr_en && byte_en[i / 8] && WMASK[i]) begin
                reg_d[i] = wr_data[i];
            end
        end
    end

    // read-only bits stay at reset value, which is zero
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_q <= RST_VAL;
        end else if (clk_en) begin
            reg_q <= reg_d & WMASK;
        end
    end

    assign value = reg_q;
endmodule // srcg_cfg_reg

`default_nettype wire

// ===== tb/srcg_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checker
module srcg_ctrl_chk (
    // bus
    input wire ref_clk, arst_n, clk_en, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i, wb_dat_o,
    // controls
    input wire overclock_spread_engine_reset, tdc_pll_logic_reset, refin_monitor_reset,
    input wire refin_monitor_gate, fuse_interface_gate
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // a request only counts while the block is not frozen
    wire rq = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && clk_en;
    wire w0 = rq && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0];
    wire w4 = rq && wb_we_i && wb_adr_i == 8'h04 && wb_sel_i[0];
    a_answer_next: assert property (rq |=> wb_ack_o || wb_err_o) else $error("no answer");
    a_unmapped_err: assert property (rq && wb_adr_i != 8'h00 && wb_adr_i != 8'h04
        |=> wb_err_o && !wb_ack_o) else $error("no err");
    a_ocss_follow: assert property (w0 |-> ##2
        overclock_spread_engine_reset == $past(wb_dat_i[7], 2)) else $error("bit 7");
    a_tdc_follow: assert property (w0 |-> ##2
        tdc_pll_logic_reset == $past(wb_dat_i[6], 2)) else $error("bit 6");
    a_refin_follow: assert property (w0 |-> ##2
        refin_monitor_reset == $past(wb_dat_i[4], 2)) else $error("bit 4");
    a_refin_gate: assert property (w4 |-> ##2
        refin_monitor_gate == $past(wb_dat_i[5], 2)) else $error("gate 5");
    a_fuse_gate: assert property (w4 |-> ##2
        fuse_interface_gate == $past(wb_dat_i[0], 2)) else $error("gate 0");
    a_ro_zero: assert property (wb_ack_o && !wb_we_i |->
        !wb_dat_o[31:8] && (wb_adr_i != 8'h04 || !wb_dat_o[7])) else $error("ro bits");
    cover property (w0);
    cover property (w4);
    a_freeze_hold: assert property (!clk_en |=> $stable(wb_ack_o) && $stable(wb_err_o)
        && $stable(overclock_spread_engine_reset) && $stable(fuse_interface_gate))
        else $error("freeze");
    cover property (wb_err_o);
    cover property (!clk_en && wb_cyc_i);
endmodule // srcg_ctrl_chk
bind srcg_ctrl srcg_ctrl_chk u_chk (.*);
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "srcg_defs.vh"
module tb_top;
    logic ref_clk = 0, arst_n = 0, clk_en = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, er;
    logic [7:0] wb_adr_i = 0, ad;
    logic [3:0] wb_sel_i = 0, s = 0;
    logic [31:0] wb_dat_i = 0, rd;
    logic [15:0] m0 = 0, m4 = 0, v;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, wb_err_o;
    wire [12:0] o;
    int bad_count = 0, comparisons = 0;
    srcg_ctrl dut (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .overclock_spread_engine_reset(o[12]), .tdc_pll_logic_reset(o[11]),
        .refin_monitor_reset(o[10]), .input3_monitor_reset(o[9]), .input2_monitor_reset(o[8]),
        .input1_monitor_reset(o[7]), .input0_monitor_reset(o[6]), .refin_monitor_gate(o[5]),
        .input3_monitor_gate(o[4]), .input2_monitor_gate(o[3]), .input1_monitor_gate(o[2]),
        .input0_monitor_gate(o[1]), .fuse_interface_gate(o[0]));
    initial forever #2.5 ref_clk = ~ref_clk;
    task chk(input [31:0] got, input [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task end_sim;
        $display("bad_count %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // request held until ack or err is sampled high at a rising edge
    task wb(input w, input [7:0] a, input [15:0] d);
        @(posedge ref_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} <= {2'b11, w, a};
        {wb_sel_i, wb_dat_i} <= {s, 16'h0, d};
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        rd = wb_dat_o;
        er = wb_err_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    endtask
    function [15:0] upd(input [15:0] q, mk);
        logic [15:0] be;
        be = {{8{s[1]}}, {8{s[0]}}};
        return ((q & ~be) | (v & be)) & mk;
    endfunction
    initial begin
        void'($urandom(34));
        repeat (6) @(posedge ref_clk);
        arst_n <= 1;
        for (int i = 0; i < 40; i++) begin
            // all-ones writes first, then random lanes and addresses
            ad = i < 2 ? 8'(i * 4) : 8'($urandom % 3 * 4);
            v = i < 2 ? 16'hffff : 16'($urandom);
            s = i < 2 ? 4'h3 : 4'($urandom);
            wb(1, ad, v);
            chk(er, ad == 8);
            if (ad == 0) m0 = upd(m0, `SRCG_SWRST_WMASK);
            if (ad == 4) m4 = upd(m4, `SRCG_CGATE_WMASK);
            wb(0, ad, 16'h0);
            if (ad != 8) chk(rd, ad == 0 ? m0 : m4);
            chk(o, {m0[7:6], m0[4:0], m4[5:0]});
        end
        // directed: software sequences kept by the far side
        s = 4'h3;
        v = 16'h0040;
        wb(1, 8'h00, v);
        m0 = upd(m0, `SRCG_SWRST_WMASK);
        @(negedge ref_clk);
        chk(o[11], 1'b1);
        v = m0 | 16'h0001;
        wb(1, 8'h00, v);
        m0 = upd(m0, `SRCG_SWRST_WMASK);
        @(negedge ref_clk);
        chk(o[6], 1'b1);
        v = 16'h0000;
        wb(1, 8'h04, v);
        m4 = upd(m4, `SRCG_CGATE_WMASK);
        @(negedge ref_clk);
        chk(o[0], 1'b0);
        // frozen block: the request waits until clk_en returns
        v = 16'h0081;
        clk_en <= 1'b0;
        fork
            wb(1, 8'h00, v);
            begin
                repeat (4) @(posedge ref_clk);
                chk(wb_ack_o, 1'b0);
                clk_en <= 1'b1;
            end
        join
        m0 = upd(m0, `SRCG_SWRST_WMASK);
        @(negedge ref_clk);
        chk(o, {m0[7:6], m0[4:0], m4[5:0]});
        @(posedge ref_clk) arst_n <= 0;
        @(posedge ref_clk) arst_n <= 1;
        wb(0, 8'h00, 16'h0);
        chk(rd, 0);
        chk(o, 0);
        end_sim;
    end
    initial begin
        #20000;
        chk(0, 1);
        end_sim;
    end
endmodule // tb_top
`default_nettype wire
